// ===== common/tcp_pkg.sv
// Shared constants and types for the timer capture and PWM unit
package tcp_pkg;
  localparam int NCH = 2;
  // Register byte addresses, one 8-bit register per aligned word
  localparam logic [7:0] ADDR_TSC = 8'h00;
  localparam logic [7:0] ADDR_CNTH = 8'h04;
  localparam logic [7:0] ADDR_CNTL = 8'h08;
  localparam logic [7:0] ADDR_MODH = 8'h0C;
  localparam logic [7:0] ADDR_MODL = 8'h10;
  localparam logic [7:0] ADDR_CH_BASE = 8'h14;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h0C;
  localparam logic [7:0] CH_OFS_SC = 8'h00;
  localparam logic [7:0] CH_OFS_VH = 8'h04;
  localparam logic [7:0] CH_OFS_VL = 8'h08;
  // Field positions of timer_status_control
  localparam int TSC_TOF = 7;
  localparam int TSC_OVERFLOW_IRQ_ENABLE = 6;
  localparam int TSC_CENTER_ALIGNED_SELECT = 5;
  localparam int TSC_CLKS_HI = 4;
  localparam int TSC_CLKS_LO = 3;
  // Field positions of channel_status_control
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELSB = 3;
  localparam int CSC_ELSA = 2;
  // Clock source select codes
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  // Edge and level select codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_01 = 2'h1;
  localparam logic [1:0] ELS_10 = 2'h2;
  localparam logic [1:0] ELS_11 = 2'h3;
  // Values after reset and counter limits
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_CENTER_PWM
  } tcp_mode_t;
endpackage

// ===== rtl/tcp_timer.sv
// Timer with capture, compare and PWM channels behind an AXI4-Lite slave
// Operation
// - Reset clears both bytes of every channel value register.
// - Capture mode: reading either value byte freezes both until the other is read.
// - Writing channel status/control releases a half-done capture read latch.
// - Compare/PWM: value bytes go to a buffer, moved as one word when paired.
// - Writing channel status/control discards a half-written value buffer.
// - Clock select resets to off; 01 bus clock, others fixed or external.
// - Counting pauses in background debug; stop and wait need nothing extra.
// - Center-aligned select makes counter up/down and all channels center PWM.
// - Up-count runs 0x0000 to terminal count then wraps to 0x0000.
// - Up/down counts 0x0000 to modulus and back, ends one tick each.
// - Overflow request is a level while enable and overflow flag are set.
// - Up-count sets overflow flag on terminal count to 0x0000 step.
// - Up/down sets overflow flag when turning down from the modulus.
// - Reading a counter byte freezes both bytes until both are read.
// - Writing either counter byte clears counter and its read latch.
// - Selected capture edge copies counter to value and sets event flag.
// - Compare match sets, clears or toggles pin and sets event flag.
// - Channel event flag raises a channel request when enabled.
// - Edge PWM: period from modulus, duty from value, polarity swaps levels.
// - Edge PWM: value 0 gives 0% duty, value above modulus 100%.
// - Edge PWM: buffered value loads only when paired and counter is zero.
// - Mode 00 capture, 01 compare, 1X edge PWM; edge/level 00 frees pin.
// - Capture edge/level 01 rising, 10 falling, 11 either edge.
// - Compare edge/level 00 no pin change, 01 toggle, 10 clear, 11 set.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tcp_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_active,
  input wire logic fixed_clk_pin,
  input wire logic ext_clk_pin,
  input wire logic [tcp_pkg::NCH-1:0] ch_pin_in,
  output logic [tcp_pkg::NCH-1:0] ch_pin_out,
  output logic [tcp_pkg::NCH-1:0] ch_pin_oe,
  output logic overflow_irq,
  output logic [tcp_pkg::NCH-1:0] channel_irq
);
  localparam int NS = tcp_pkg::NCH + 2;

  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_mux;
  logic rd_hit;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] pin_rise;
  logic [NS-1:0] pin_fall;
  logic overflow_irq_enable;
  logic center_aligned_select;
  logic [1:0] clk_sel;
  logic overflow_flag;
  logic tof_armed;
  logic tick;
  logic tick_q;
  logic ovf_evt;
  logic [15:0] cnt;
  logic [15:0] term;
  logic dir_up;
  logic [15:0] cnt_buf;
  logic cnt_rd_h;
  logic cnt_rd_l;
  logic [15:0] cnt_view;
  logic [15:0] modulus;
  logic [15:0] mod_buf;
  logic mod_wh;
  logic mod_wl;
  logic [7:0] ch_sc [tcp_pkg::NCH];
  logic [15:0] ch_val [tcp_pkg::NCH];
  logic [7:0] ch_rd_val [tcp_pkg::NCH];
  logic [tcp_pkg::NCH-1:0] ch_rd_hit;

  // Write path: address and data taken in either order, then one write pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcp_pkg::RESP_OKAY;
      aw_addr <= tcp_pkg::REG_RESET;
      w_data <= tcp_pkg::REG_RESET;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit(aw_addr) ? tcp_pkg::RESP_OKAY
                                       : tcp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writes whose low byte lane is off store nothing but still answer
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;

  function automatic logic wr_hit(input logic [7:0] a);
    logic h;
    h = (a == tcp_pkg::ADDR_TSC) || (a == tcp_pkg::ADDR_CNTH) ||
        (a == tcp_pkg::ADDR_CNTL) || (a == tcp_pkg::ADDR_MODH) ||
        (a == tcp_pkg::ADDR_MODL);
    for (int i = 0; i < tcp_pkg::NCH; i++) begin
      for (int k = 0; k < 3; k++) begin
        if (a == 8'(tcp_pkg::ADDR_CH_BASE + i * tcp_pkg::ADDR_CH_STRIDE
                    + k * 4)) begin
          h = 1'b1;
        end
      end
    end
    return h;
  endfunction

  function automatic logic wr_to(input logic [7:0] a);
    return wr_en && w_lane0 && (aw_addr == a);
  endfunction

  // Read path: data registered at the address handshake, side effects there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tcp_pkg::RESP_OKAY;
    end else begin
      if (rd_en) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_mux};
        s_axi_rresp <= rd_hit ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Read multiplexer over timer and channel registers
  always_comb begin
    rd_mux = tcp_pkg::REG_RESET;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      tcp_pkg::ADDR_TSC: rd_mux = {overflow_flag, overflow_irq_enable, center_aligned_select, clk_sel, 3'h0};
      tcp_pkg::ADDR_CNTH: rd_mux = cnt_view[15:8];
      tcp_pkg::ADDR_CNTL: rd_mux = cnt_view[7:0];
      tcp_pkg::ADDR_MODH: rd_mux = modulus[15:8];
      tcp_pkg::ADDR_MODL: rd_mux = modulus[7:0];
      default: rd_hit = 1'b0;
    endcase
    for (int i = 0; i < tcp_pkg::NCH; i++) begin
      if (ch_rd_hit[i]) begin
        rd_mux = ch_rd_val[i];
        rd_hit = 1'b1;
      end
    end
  end

  // Three-stage synchronisers; a level counts once stages two and three agree
  assign pin_raw = {ext_clk_pin, fixed_clk_pin, ch_pin_in};
  for (genvar s = 0; s < NS; s++) begin : g_sync
    logic [2:0] sh;
    logic lvl;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sh <= 3'h0;
        lvl <= 1'b0;
      end else begin
        sh <= {sh[1:0], pin_raw[s]};
        if (sh[1] == sh[2]) begin
          lvl <= sh[2];
        end
      end
    end
    assign pin_rise[s] = (sh[1] == sh[2]) && sh[2] && !lvl;
    assign pin_fall[s] = (sh[1] == sh[2]) && !sh[2] && lvl;
  end

  // Timer control; overflow flag cleared by read-while-set then write 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_enable <= 1'b0;
      center_aligned_select <= 1'b0;
      clk_sel <= tcp_pkg::CLK_OFF;
      overflow_flag <= 1'b0;
      tof_armed <= 1'b0;
    end else begin
      if (wr_to(tcp_pkg::ADDR_TSC)) begin
        overflow_irq_enable <= w_data[tcp_pkg::TSC_OVERFLOW_IRQ_ENABLE];
        center_aligned_select <= w_data[tcp_pkg::TSC_CENTER_ALIGNED_SELECT];
        clk_sel <= w_data[tcp_pkg::TSC_CLKS_HI:tcp_pkg::TSC_CLKS_LO];
        if (tof_armed && !w_data[tcp_pkg::TSC_TOF]) begin
          overflow_flag <= 1'b0;
          tof_armed <= 1'b0;
        end
      end
      if (rd_en && s_axi_araddr == tcp_pkg::ADDR_TSC && overflow_flag) begin
        tof_armed <= 1'b1;
      end
      // A new overflow wins over the clear and restarts the sequence
      if (ovf_evt) begin
        overflow_flag <= 1'b1;
        tof_armed <= 1'b0;
      end
    end
  end

  // Count enable; external rates above a quarter of aclk lose edges
  always_comb begin
    unique case (clk_sel)
      tcp_pkg::CLK_OFF: tick = 1'b0;
      tcp_pkg::CLK_BUS: tick = 1'b1;
      tcp_pkg::CLK_FIXED: tick = pin_rise[tcp_pkg::NCH];
      tcp_pkg::CLK_EXT: tick = pin_rise[tcp_pkg::NCH + 1];
    endcase
    if (debug_active) begin
      tick = 1'b0;
    end
  end

  assign term = (modulus == tcp_pkg::CNT_ZERO) ? tcp_pkg::CNT_MAX : modulus;
  assign ovf_evt = tick && (center_aligned_select ? (dir_up && cnt == modulus)
                                  : (cnt == term));

  // Main counter, up or up/down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= tcp_pkg::CNT_ZERO;
      dir_up <= 1'b1;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
      if (wr_to(tcp_pkg::ADDR_CNTH) || wr_to(tcp_pkg::ADDR_CNTL)) begin
        cnt <= tcp_pkg::CNT_ZERO;
        dir_up <= 1'b1;
      end else if (tick && center_aligned_select) begin
        if (dir_up && cnt == modulus) begin
          dir_up <= 1'b0;
          cnt <= cnt - 16'h0001;
        end else if (!dir_up && cnt == tcp_pkg::CNT_ZERO) begin
          dir_up <= 1'b1;
          cnt <= cnt + 16'h0001;
        end else begin
          cnt <= dir_up ? cnt + 16'h0001 : cnt - 16'h0001;
        end
      end else if (tick) begin
        dir_up <= 1'b1;
        cnt <= (cnt == term) ? tcp_pkg::CNT_ZERO : cnt + 16'h0001;
      end
    end
  end

  // Counter read latch: first byte read freezes both until the other is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_buf <= tcp_pkg::CNT_ZERO;
      cnt_rd_h <= 1'b0;
      cnt_rd_l <= 1'b0;
    end else if (wr_to(tcp_pkg::ADDR_CNTH) || wr_to(tcp_pkg::ADDR_CNTL)) begin
      cnt_rd_h <= 1'b0;
      cnt_rd_l <= 1'b0;
    end else if (rd_en && s_axi_araddr == tcp_pkg::ADDR_CNTH) begin
      if (cnt_rd_l) begin
        cnt_rd_l <= 1'b0;
      end else begin
        if (!cnt_rd_h) cnt_buf <= cnt;
        cnt_rd_h <= 1'b1;
      end
    end else if (rd_en && s_axi_araddr == tcp_pkg::ADDR_CNTL) begin
      if (cnt_rd_h) begin
        cnt_rd_h <= 1'b0;
      end else begin
        if (!cnt_rd_l) cnt_buf <= cnt;
        cnt_rd_l <= 1'b1;
      end
    end
  end

  assign cnt_view = (cnt_rd_h || cnt_rd_l) ? cnt_buf : cnt;

  // Modulus write pairing; writing timer control drops a half-written value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulus <= tcp_pkg::CNT_ZERO;
      mod_buf <= tcp_pkg::CNT_ZERO;
      mod_wh <= 1'b0;
      mod_wl <= 1'b0;
    end else if (wr_to(tcp_pkg::ADDR_TSC)) begin
      mod_wh <= 1'b0;
      mod_wl <= 1'b0;
    end else begin
      if (wr_to(tcp_pkg::ADDR_MODH)) begin
        mod_buf[15:8] <= w_data;
        mod_wh <= 1'b1;
      end
      if (wr_to(tcp_pkg::ADDR_MODL)) begin
        mod_buf[7:0] <= w_data;
        mod_wl <= 1'b1;
      end
      if (mod_wh && mod_wl) begin
        modulus <= mod_buf;
        mod_wh <= 1'b0;
        mod_wl <= 1'b0;
      end
    end
  end

  // Registered overflow request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  // Channels
  for (genvar g = 0; g < tcp_pkg::NCH; g++) begin : g_ch
    localparam logic [7:0] A_SC = 8'(tcp_pkg::ADDR_CH_BASE
        + g * tcp_pkg::ADDR_CH_STRIDE + tcp_pkg::CH_OFS_SC);
    localparam logic [7:0] A_VH = 8'(tcp_pkg::ADDR_CH_BASE
        + g * tcp_pkg::ADDR_CH_STRIDE + tcp_pkg::CH_OFS_VH);
    localparam logic [7:0] A_VL = 8'(tcp_pkg::ADDR_CH_BASE
        + g * tcp_pkg::ADDR_CH_STRIDE + tcp_pkg::CH_OFS_VL);
    tcp_pkg::tcp_mode_t mode;
    logic [1:0] els;
    logic [15:0] wbuf;
    logic wh;
    logic wl;
    logic [15:0] rbuf;
    logic rd_h;
    logic rd_l;
    logic armed;
    logic cap_evt;
    logic match;
    logic load_ok;
    logic sc_wr;

    assign els = ch_sc[g][tcp_pkg::CSC_ELSB:tcp_pkg::CSC_ELSA];
    // Spelled out: a continuous assign would not see the function's globals
    assign sc_wr = wr_en && w_lane0 && (aw_addr == A_SC);
    // Center select overrides every channel's own mode bits
    always_comb begin
      if (center_aligned_select) mode = tcp_pkg::MODE_CENTER_PWM;
      else if (ch_sc[g][tcp_pkg::CSC_MSB]) mode = tcp_pkg::MODE_EDGE_PWM;
      else if (ch_sc[g][tcp_pkg::CSC_MSA]) mode = tcp_pkg::MODE_COMPARE;
      else mode = tcp_pkg::MODE_CAPTURE;
    end
    assign cap_evt = (mode == tcp_pkg::MODE_CAPTURE) &&
        ((els[0] && pin_rise[g]) || (els[1] && pin_fall[g]));
    // Match tested the cycle after the counter moved, once per count
    assign match = tick_q && (cnt == ch_val[g]) &&
                   (mode != tcp_pkg::MODE_CAPTURE);
    assign load_ok = (mode == tcp_pkg::MODE_EDGE_PWM) ?
        (cnt == tcp_pkg::CNT_ZERO) :
        (mode == tcp_pkg::MODE_CENTER_PWM) ? ovf_evt : 1'b1;

    // Control and event flag; a new event beats the clearing write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_sc[g] <= tcp_pkg::REG_RESET;
        armed <= 1'b0;
      end else begin
        if (sc_wr) begin
          ch_sc[g][6:2] <= w_data[6:2];
          if (armed && !w_data[tcp_pkg::CSC_FLAG]) begin
            ch_sc[g][tcp_pkg::CSC_FLAG] <= 1'b0;
            armed <= 1'b0;
          end
        end
        if (rd_en && s_axi_araddr == A_SC && ch_sc[g][tcp_pkg::CSC_FLAG]) begin
          armed <= 1'b1;
        end
        if (cap_evt || match) begin
          ch_sc[g][tcp_pkg::CSC_FLAG] <= 1'b1;
          armed <= 1'b0;
        end
      end
    end

    // Value write buffer and active value
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_val[g] <= tcp_pkg::CNT_ZERO;
        wbuf <= tcp_pkg::CNT_ZERO;
        wh <= 1'b0;
        wl <= 1'b0;
      end else begin
        if (sc_wr) begin
          wh <= 1'b0;
          wl <= 1'b0;
        end else begin
          if (wr_to(A_VH)) begin
            wbuf[15:8] <= w_data;
            wh <= 1'b1;
          end
          if (wr_to(A_VL)) begin
            wbuf[7:0] <= w_data;
            wl <= 1'b1;
          end
          if (wh && wl && load_ok) begin
            ch_val[g] <= wbuf;
            wh <= 1'b0;
            wl <= 1'b0;
          end
        end
        if (cap_evt) begin
          ch_val[g] <= cnt;
        end
      end
    end

    // Capture read latch, released by the other byte or a control write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rbuf <= tcp_pkg::CNT_ZERO;
        rd_h <= 1'b0;
        rd_l <= 1'b0;
      end else if (sc_wr) begin
        rd_h <= 1'b0;
        rd_l <= 1'b0;
      end else if (rd_en && mode == tcp_pkg::MODE_CAPTURE) begin
        if (s_axi_araddr == A_VH) begin
          if (rd_l) rd_l <= 1'b0;
          else begin
            if (!rd_h) rbuf <= ch_val[g];
            rd_h <= 1'b1;
          end
        end else if (s_axi_araddr == A_VL) begin
          if (rd_h) rd_h <= 1'b0;
          else begin
            if (!rd_l) rbuf <= ch_val[g];
            rd_l <= 1'b1;
          end
        end
      end
    end

    always_comb begin
      ch_rd_hit[g] = 1'b1;
      unique case (s_axi_araddr)
        A_SC: ch_rd_val[g] = {ch_sc[g][7:2], 2'h0};
        A_VH: ch_rd_val[g] = (rd_h || rd_l) ? rbuf[15:8] : ch_val[g][15:8];
        A_VL: ch_rd_val[g] = (rd_h || rd_l) ? rbuf[7:0] : ch_val[g][7:0];
        default: begin
          ch_rd_val[g] = tcp_pkg::REG_RESET;
          ch_rd_hit[g] = 1'b0;
        end
      endcase
    end

    // Pin drive; on a tie of overflow and match the match wins (0% duty)
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_pin_out[g] <= 1'b0;
        ch_pin_oe[g] <= 1'b0;
        channel_irq[g] <= 1'b0;
      end else begin
        channel_irq[g] <= ch_sc[g][tcp_pkg::CSC_FLAG] &&
                          ch_sc[g][tcp_pkg::CSC_IE];
        ch_pin_oe[g] <= (els != tcp_pkg::ELS_OFF) &&
                        (mode != tcp_pkg::MODE_CAPTURE);
        unique case (mode)
          tcp_pkg::MODE_COMPARE: begin
            if (match) begin
              unique case (els)
                tcp_pkg::ELS_01: ch_pin_out[g] <= !ch_pin_out[g];
                tcp_pkg::ELS_10: ch_pin_out[g] <= 1'b0;
                tcp_pkg::ELS_11: ch_pin_out[g] <= 1'b1;
                tcp_pkg::ELS_OFF: ch_pin_out[g] <= ch_pin_out[g];
              endcase
            end
          end
          tcp_pkg::MODE_EDGE_PWM: begin
            if (match) ch_pin_out[g] <= els[0];
            else if (tick_q && cnt == tcp_pkg::CNT_ZERO)
              ch_pin_out[g] <= !els[0];
          end
          tcp_pkg::MODE_CENTER_PWM: begin
            if (match) ch_pin_out[g] <= dir_up ? els[0] : !els[0];
          end
          tcp_pkg::MODE_CAPTURE: ch_pin_out[g] <= 1'b0;
        endcase
      end
    end

    a_val_reset: assert property (@(posedge aclk)
      $past(!aresetn) |-> ch_val[g] == tcp_pkg::CNT_ZERO)
      else $error("channel value not cleared by reset");
    a_cap_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_evt |=> ch_val[g] == $past(cnt) && ch_sc[g][7])
      else $error("capture did not copy counter or set flag");
    a_sc_release: assert property (@(posedge aclk) disable iff (!aresetn)
      sc_wr |=> !rd_h && !rd_l && !wh && !wl)
      else $error("control write did not release byte latches");
    a_cmp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      match |=> ch_sc[g][tcp_pkg::CSC_FLAG] ##1 (channel_irq[g] ==
        ch_sc[g][tcp_pkg::CSC_IE]))
      else $error("match flag or channel request missing");
  end

  a_clk_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_sel == tcp_pkg::CLK_OFF || debug_active) |-> !tick)
    else $error("counter ticked while off or in debug");
  a_up_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !center_aligned_select && cnt == term && !wr_en) |=>
      cnt == tcp_pkg::CNT_ZERO && overflow_flag)
    else $error("up count did not wrap with overflow");
  a_turn_down: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && center_aligned_select && dir_up && cnt == modulus && !wr_en) |=>
      !dir_up && cnt == $past(modulus) - 16'h0001 && overflow_flag)
    else $error("up/down turn at modulus wrong");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 overflow_irq == $past(overflow_flag && overflow_irq_enable))
    else $error("overflow request does not follow flag and enable");
  a_cnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && w_lane0 && (aw_addr == tcp_pkg::ADDR_CNTH ||
      aw_addr == tcp_pkg::ADDR_CNTL)) |=>
      cnt == tcp_pkg::CNT_ZERO && !cnt_rd_h && !cnt_rd_l)
    else $error("counter write did not clear count and latch");
endmodule
`default_nettype wire

// ===== sim/tcp_pin_model.sv
// Far side model: channel pins and timer clock inputs
`timescale 1ns/10ps
`default_nettype none
module tcp_pin_model (
  input wire logic aclk,
  input wire logic [1:0] pin_req,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in,
  output logic fixed_clk,
  output logic ext_clk
);
  logic [1:0] div = 2'h0;
  // External clocks at a quarter of aclk, the fastest allowed
  always @(posedge aclk) begin
    div <= div + 2'h1;
  end
  assign ext_clk = div[1];
  assign fixed_clk = div[1];
  // Wire level: the timer wins while it drives the pin
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_req);
endmodule
`default_nettype wire

// ===== sim/timer_capture_pwm_unit_tb.sv
// Register level testbench for the timer unit
`timescale 1ns/10ps
`default_nettype none
module timer_capture_pwm_unit_tb;
  localparam logic [7:0] C0 = tcp_pkg::ADDR_CH_BASE;
  localparam logic [7:0] C1 = C0 + tcp_pkg::ADDR_CH_STRIDE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, d, h, l;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ovf_irq;
  logic [1:0] bresp, rresp, rr, pin_req = 2'h0, pout, poe, pin, chirq;
  logic dbg = 0, fclk, eclk;
  int mismatches = 0, total_checks = 0;
  always #5 aclk = ~aclk;
  tcp_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .debug_active(dbg), .fixed_clk_pin(fclk),
    .ext_clk_pin(eclk), .ch_pin_in(pin), .ch_pin_out(pout),
    .ch_pin_oe(poe), .overflow_irq(ovf_irq), .channel_irq(chirq));
  tcp_pin_model pm (.aclk(aclk), .pin_req(pin_req), .pin_out(pout),
    .pin_oe(poe), .pin_in(pin), .fixed_clk(fclk), .ext_clk(eclk));
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 0;
    if (n >= 50) begin
      mismatches++;
      give_verdict;
    end
  endtask
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata[7:0];
    rr = rresp;
    rready <= 0;
    if (n >= 50) begin
      mismatches++;
      give_verdict;
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(tcp_pkg::ADDR_TSC);
    chk(d, 8'h00);
    rd(C0 + 8'h04);
    chk(d, 8'h00);
    rd(C0 + 8'h08);
    chk(d, 8'h00);
    rd(8'hFC);
    chk(rr, 2'h2);
    // Compare mode: a control write drops the half pair
    wr(C0, 8'h10);
    wr(C0 + 8'h04, 8'h12);
    wr(C0, 8'h10);
    wr(C0 + 8'h08, 8'h34);
    rd(C0 + 8'h08);
    chk(d, 8'h00);
    wr(C0 + 8'h04, 8'h12);
    rd(C0 + 8'h04);
    chk(d, 8'h12);
    rd(C0 + 8'h08);
    chk(d, 8'h34);
    // Short modulus so overflow comes quickly
    wr(tcp_pkg::ADDR_MODL, 8'h05);
    wr(tcp_pkg::ADDR_MODH, 8'h00);
    wr(tcp_pkg::ADDR_TSC, 8'h48);
    repeat (20) @(posedge aclk);
    rd(tcp_pkg::ADDR_TSC);
    chk(d[7], 1'b1);
    chk(ovf_irq, 1'b1);
    rd(tcp_pkg::ADDR_CNTH);
    chk(d, 8'h00);
    rd(tcp_pkg::ADDR_CNTL);
    chk(d < 8'h06, 1'b1);
    // Debug halts counting after a counter clear
    dbg <= 1;
    wr(tcp_pkg::ADDR_CNTL, 8'hA5);
    repeat (10) @(posedge aclk);
    rd(tcp_pkg::ADDR_CNTL);
    chk(d, 8'h00);
    dbg <= 0;
    // Freeze the counter, then capture it on a rising pin edge
    wr(tcp_pkg::ADDR_TSC, 8'h08);
    repeat (3) @(posedge aclk);
    wr(tcp_pkg::ADDR_TSC, 8'h00);
    rd(tcp_pkg::ADDR_CNTH);
    h = d;
    rd(tcp_pkg::ADDR_CNTL);
    l = d;
    wr(C1, 8'h04);
    pin_req <= 2'h2;
    repeat (8) @(posedge aclk);
    rd(C1);
    chk(d[7], 1'b1);
    rd(C1 + 8'h08);
    chk(d, l);
    rd(C1 + 8'h04);
    chk(d, h);
    // Clear the flag, then capture on a falling edge only
    rd(C1);
    wr(C1, 8'h08);
    rd(C1);
    chk(d, 8'h08);
    pin_req <= 2'h0;
    repeat (8) @(posedge aclk);
    rd(C1);
    chk(d, 8'h88);
    // Compare at 3: set the pin with a request, then toggle, then clear
    wr(C0 + 8'h08, 8'h03);
    wr(C0 + 8'h04, 8'h00);
    wr(C0, 8'h5C);
    wr(tcp_pkg::ADDR_TSC, 8'h08);
    repeat (12) @(posedge aclk);
    chk({poe[0], pout[0]}, 2'h3);
    chk(chirq, 2'h1);
    wr(C0, 8'h54);
    h[0] = pout[0];
    // One match in every six counts, so the level must have flipped
    repeat (6) @(posedge aclk);
    chk(pout[0] != h[0], 1'b1);
    wr(C0, 8'h58);
    repeat (8) @(posedge aclk);
    chk(pout[0], 1'b0);
    // Edge PWM high-true: above modulus, half, then zero duty
    wr(C0, 8'h28);
    wr(C0 + 8'h08, 8'h09);
    wr(C0 + 8'h04, 8'h00);
    repeat (12) @(posedge aclk);
    chk(pout[0], 1'b1);
    repeat (3) @(posedge aclk);
    chk(pout[0], 1'b1);
    wr(C0 + 8'h08, 8'h03);
    wr(C0 + 8'h04, 8'h00);
    repeat (12) @(posedge aclk);
    h[0] = pout[0];
    repeat (3) @(posedge aclk);
    chk(pout[0] != h[0], 1'b1);
    wr(C0 + 8'h08, 8'h00);
    wr(C0 + 8'h04, 8'h00);
    repeat (12) @(posedge aclk);
    chk(pout[0], 1'b0);
    repeat (3) @(posedge aclk);
    chk(pout[0], 1'b0);
    // Stop and clear overflow, then count up and down
    wr(tcp_pkg::ADDR_TSC, 8'h00);
    rd(tcp_pkg::ADDR_TSC);
    wr(tcp_pkg::ADDR_TSC, 8'h00);
    rd(tcp_pkg::ADDR_TSC);
    chk(d, 8'h00);
    wr(tcp_pkg::ADDR_TSC, 8'h28);
    repeat (20) @(posedge aclk);
    rd(tcp_pkg::ADDR_TSC);
    chk(d, 8'hA8);
    // Quarter-rate clock sources: ten cycles give two to four counts
    wr(tcp_pkg::ADDR_TSC, 8'h18);
    wr(tcp_pkg::ADDR_CNTL, 8'h00);
    repeat (10) @(posedge aclk);
    rd(tcp_pkg::ADDR_CNTL);
    chk(d > 8'h01 && d < 8'h05, 1'b1);
    wr(tcp_pkg::ADDR_TSC, 8'h10);
    wr(tcp_pkg::ADDR_CNTH, 8'h00);
    repeat (10) @(posedge aclk);
    rd(tcp_pkg::ADDR_CNTL);
    chk(d > 8'h01 && d < 8'h05, 1'b1);
    give_verdict;
  end
endmodule
`default_nettype wire
